// *** core/eie_pkg.sv ***
package eie_pkg;

  // Data path widths
  localparam int DATA_W = 8;
  localparam int PWORD_W = 16;
  localparam int DMEM_DEPTH = 256;
  localparam int DMEM_AW = 8;
  localparam int PMEM_DEPTH = 512;
  localparam int PMEM_AW = 9;
  localparam int BUS_AW = 13;

  // Register byte offsets on the bus
  localparam logic [12:0] REG_CMD = 13'h0000;
  localparam logic [12:0] REG_STATUS = 13'h0004;
  localparam logic [12:0] REG_WORK = 13'h0008;
  localparam logic [12:0] REG_FLAGS = 13'h000C;
  localparam logic [12:0] REG_TBL_PTR = 13'h0010;
  localparam logic [12:0] REG_TBL_HIGH = 13'h0014;

  // Memory windows, one word per entry
  localparam logic [2:0] DMEM_REGION = 3'h1;
  localparam logic [1:0] PMEM_REGION = 2'h1;

  // Status register field positions
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SKIP_BIT = 1;
  localparam int ST_CYC_LSB = 4;

  // Reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

  // Instruction timing, in clocks and instruction cycles
  localparam int CLKS_PER_ICYCLE = 4;
  localparam logic [1:0] CYC_NORMAL = 2'h2;
  localparam logic [1:0] CYC_SKIP = 2'h3;
  localparam int TMR_W = 4;

  // Operation codes in command bits [4:0], in this order
  typedef enum logic [4:0] {
    OP_SUB_BORROW_TO_MEM,
    OP_DEC_SKIP_ZERO_MEM,
    OP_DEC_SKIP_ZERO_WORK,
    OP_SET_ALL_BITS,
    OP_SET_BIT,
    OP_INC_SKIP_ZERO_MEM,
    OP_INC_SKIP_ZERO_WORK,
    OP_SKIP_IF_NONZERO_BIT,
    OP_SKIP_IF_NONZERO,
    OP_SUBTRACT_TO_WORK,
    OP_SUBTRACT_TO_MEM,
    OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_WORK,
    OP_SKIP_IF_ZERO,
    OP_MOVE_TEST_SKIP,
    OP_SKIP_IF_ZERO_BIT,
    OP_TABLE_READ_PAGED,
    OP_XOR_TO_WORK,
    OP_XOR_TO_MEM
  } eie_op_t;

  // Command word: address [15:8], bit select [7:5], operation [4:0]
  typedef struct packed {
    logic [7:0] addr;
    logic [2:0] bit_sel;
    eie_op_t op;
  } eie_cmd_t;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic chained_zero_flag;
    logic signed_compare_flag;
    logic signed_wrap_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } eie_flags_t;

  // Outcome of one executed instruction
  typedef struct packed {
    logic [7:0] result;
    logic wr_mem;
    logic wr_work;
    logic wr_tbl;
    logic skip;
    eie_flags_t flags;
  } eie_alu_t;

endpackage

// *** core/eie_alu.sv ***
`timescale 1ns/1ps
module eie_alu
  import eie_pkg::*;
(
  // Decoded instruction and operands
  input wire eie_cmd_t cmd,
  input wire logic [7:0] work,
  input wire logic [7:0] operand,
  input wire logic [15:0] pword,
  input wire eie_flags_t flags,
  // Outcome
  output eie_alu_t res
);

  logic cin;
  logic [8:0] full;
  logic [4:0] half;
  logic [7:0] diff;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] swap_v;
  logic [7:0] xor_v;
  logic sel_bit;
  eie_flags_t sub_f;

  // Subtract as add of complement; carry out means no borrow
  assign cin = (cmd.op == OP_SUB_BORROW_TO_MEM) ? flags.carry_flag : 1'b1;
  assign full = {1'b0, work} + {1'b0, ~operand} + {8'h00, cin};
  assign half = {1'b0, work[3:0]} + {1'b0, ~operand[3:0]} + {4'h0, cin};
  assign diff = full[7:0];
  // Wrap arithmetic is modulo 256, so 01h-1 and FFh+1 both give zero
  assign dec_v = operand - BYTE_ONE;
  assign inc_v = operand + BYTE_ONE;
  assign swap_v = {operand[3:0], operand[7:4]};
  assign xor_v = work ^ operand;
  assign sel_bit = operand[cmd.bit_sel];

  // Flags of every subtract; only these six are touched
  always_comb
  begin
    sub_f = flags;
    sub_f.carry_flag = full[8];
    sub_f.half_carry_flag = half[4];
    sub_f.zero_flag = (diff == BYTE_ZERO);
    sub_f.signed_wrap_flag = (work[7] ^ operand[7]) & (diff[7] ^ work[7]);
    sub_f.signed_compare_flag = ~(sub_f.signed_wrap_flag ^ diff[7]);
    // Borrow form chains zero across bytes of a wide subtract
    sub_f.chained_zero_flag = (cmd.op == OP_SUB_BORROW_TO_MEM) ?
      (sub_f.zero_flag & flags.chained_zero_flag) : sub_f.zero_flag;
  end

  // Per-operation destination, skip and flag selection
  always_comb
  begin
    res = '0;
    res.flags = flags;
    unique case (cmd.op)
      OP_SUB_BORROW_TO_MEM, OP_SUBTRACT_TO_MEM:
      begin
        res.result = diff;
        res.wr_mem = 1'b1;
        res.flags = sub_f;
      end
      OP_SUBTRACT_TO_WORK:
      begin
        res.result = diff;
        res.wr_work = 1'b1;
        res.flags = sub_f;
      end
      OP_DEC_SKIP_ZERO_MEM, OP_DEC_SKIP_ZERO_WORK:
      begin
        res.result = dec_v;
        res.wr_mem = (cmd.op == OP_DEC_SKIP_ZERO_MEM);
        res.wr_work = (cmd.op == OP_DEC_SKIP_ZERO_WORK);
        res.skip = (dec_v == BYTE_ZERO);
      end
      OP_INC_SKIP_ZERO_MEM, OP_INC_SKIP_ZERO_WORK:
      begin
        res.result = inc_v;
        res.wr_mem = (cmd.op == OP_INC_SKIP_ZERO_MEM);
        res.wr_work = (cmd.op == OP_INC_SKIP_ZERO_WORK);
        res.skip = (inc_v == BYTE_ZERO);
      end
      OP_SET_ALL_BITS:
      begin
        res.result = BYTE_ALL_ONES;
        res.wr_mem = 1'b1;
      end
      OP_SET_BIT:
      begin
        res.result = operand | (BYTE_ONE << cmd.bit_sel);
        res.wr_mem = 1'b1;
      end
      OP_SKIP_IF_NONZERO_BIT: res.skip = sel_bit;
      OP_SKIP_IF_NONZERO: res.skip = (operand != BYTE_ZERO);
      OP_SKIP_IF_ZERO: res.skip = (operand == BYTE_ZERO);
      OP_SKIP_IF_ZERO_BIT: res.skip = ~sel_bit;
      OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_WORK:
      begin
        res.result = swap_v;
        res.wr_mem = (cmd.op == OP_NIBBLE_EXCHANGE);
        res.wr_work = (cmd.op == OP_NIBBLE_EXCHANGE_WORK);
      end
      OP_MOVE_TEST_SKIP:
      begin
        res.result = operand;
        res.wr_work = 1'b1;
        res.skip = (operand == BYTE_ZERO);
      end
      OP_TABLE_READ_PAGED:
      begin
        res.result = pword[7:0];
        res.wr_mem = 1'b1;
        res.wr_tbl = 1'b1;
      end
      OP_XOR_TO_WORK, OP_XOR_TO_MEM:
      begin
        res.result = xor_v;
        res.wr_work = (cmd.op == OP_XOR_TO_WORK);
        res.wr_mem = (cmd.op == OP_XOR_TO_MEM);
        res.flags.zero_flag = (xor_v == BYTE_ZERO);
      end
      // Unassigned codes execute as a no-operation
      default: res = {BYTE_ZERO, 4'h0, flags};
    endcase
  end

endmodule

// *** core/eie_icycle_timer.sv ***
`timescale 1ns/1ps
module eie_icycle_timer
  import eie_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Start with a length in instruction cycles
  input wire logic start,
  input wire logic [1:0] ncycles,
  // Completion
  output logic done
);

  logic [TMR_W-1:0] cnt_r;
  logic run_r;
  logic [TMR_W-1:0] load_v;

  // Total clocks minus one, since the load edge is the first clock
  assign load_v = TMR_W'(ncycles * CLKS_PER_ICYCLE - 1);
  assign done = run_r && (cnt_r == '0);

  // Down counter over the instruction's clocks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end
    else if (start)
    begin
      cnt_r <= load_v;
      run_r <= 1'b1;
    end
    else if (done)
      run_r <= 1'b0;
    else if (run_r)
      cnt_r <= cnt_r - 1'b1;
  end

endmodule

// *** core/eie_core.sv ***
`timescale 1ns/1ps
module eie_core
  import eie_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // AHB-Lite slave answer
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  typedef enum {ST_IDLE, ST_EXEC, ST_WAIT} eie_state_t;

  // Architectural state
  logic [7:0] dmem [DMEM_DEPTH];
  logic [15:0] pmem [PMEM_DEPTH];
  logic [7:0] working_register_r;
  eie_flags_t flags_r;
  logic [7:0] table_pointer_low_r;
  logic [7:0] table_pointer_high_r;
  logic [7:0] table_high_latch_r;
  eie_cmd_t cmd_r;
  eie_state_t state_r;
  logic last_skip_r;
  logic [1:0] last_cycles_r;

  // Bus pipeline state
  logic wr_pend_r;
  logic rd_pend_r;
  logic [BUS_AW-1:0] addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // Combinational helpers
  logic addr_phase;
  logic busy;
  logic is_reg;
  logic is_dmem;
  logic is_pmem;
  logic [DMEM_AW-1:0] dmem_idx;
  logic [PMEM_AW-1:0] pmem_idx;
  logic [PMEM_AW-1:0] tbl_idx;
  logic bus_wr;
  logic [7:0] operand;
  logic [15:0] pword;
  eie_alu_t alu;
  logic exec;
  logic tmr_done;
  logic [1:0] exec_cycles;
  logic [31:0] rd_mux;

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

  // Address decode of the data-phase address
  assign is_reg = (addr_r[12:10] == 3'h0);
  assign is_dmem = (addr_r[12:10] == DMEM_REGION);
  assign is_pmem = (addr_r[12:11] == PMEM_REGION);
  assign dmem_idx = addr_r[9:2];
  assign pmem_idx = addr_r[10:2];

  // Only word transfers are expected; size is not checked
  assign addr_phase = hsel && htrans[1] && hready;
  assign busy = (state_r != ST_IDLE);
  // Software writes to state are dropped while an instruction runs
  assign bus_wr = wr_pend_r && !busy;

  // Paged pointer: low bit of the high byte selects the page
  assign tbl_idx = {table_pointer_high_r[0], table_pointer_low_r};
  assign operand = dmem[cmd_r.addr];
  assign pword = pmem[tbl_idx];
  assign exec = (state_r == ST_EXEC);

  // Instruction execution, purely combinational
  eie_alu u_alu (
    .cmd(cmd_r),
    .work(working_register_r),
    .operand(operand),
    .pword(pword),
    .flags(flags_r),
    .res(alu)
  );

  // A taken skip costs one extra dummy instruction cycle
  assign exec_cycles = alu.skip ? CYC_SKIP : CYC_NORMAL;

  // Instruction-cycle pacing
  eie_icycle_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(exec),
    .ncycles(exec_cycles),
    .done(tmr_done)
  );

  // Capture of the address phase; reads get one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= addr_phase && hwrite;
      rd_pend_r <= addr_phase && !hwrite;
      if (addr_phase)
        addr_r <= haddr[BUS_AW-1:0];
    end
  end

  // Ready: low for the first read data cycle, so read data is a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout_r <= 1'b1;
    else if (addr_phase && !hwrite)
      hreadyout_r <= 1'b0;
    else
      hreadyout_r <= 1'b1;
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp_r <= 1'b0;
    else
      hresp_r <= 1'b0;
  end

  // Read data mux; unmapped words read as zero
  always_comb
  begin
    rd_mux = '0;
    if (is_dmem)
      rd_mux[7:0] = dmem[dmem_idx];
    else if (is_pmem)
      rd_mux[15:0] = pmem[pmem_idx];
    else if (is_reg)
    begin
      unique case (addr_r)
        REG_CMD: rd_mux[15:0] = cmd_r;
        REG_STATUS:
        begin
          rd_mux[ST_BUSY_BIT] = busy;
          rd_mux[ST_SKIP_BIT] = last_skip_r;
          rd_mux[ST_CYC_LSB +: 2] = last_cycles_r;
        end
        REG_WORK: rd_mux[7:0] = working_register_r;
        REG_FLAGS: rd_mux[5:0] = flags_r;
        REG_TBL_PTR:
          rd_mux[15:0] = {table_pointer_high_r, table_pointer_low_r};
        REG_TBL_HIGH: rd_mux[7:0] = table_high_latch_r;
        default: rd_mux = '0;
      endcase
    end
  end

  // Read data register, loaded in the wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= '0;
    else if (rd_pend_r)
      hrdata_r <= rd_mux;
  end

  // Sequencer: a command write starts one instruction
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (bus_wr && is_reg && (addr_r == REG_CMD))
            state_r <= ST_EXEC;
        ST_EXEC: state_r <= ST_WAIT;
        ST_WAIT:
          if (tmr_done)
            state_r <= ST_IDLE;
      endcase
    end
  end

  // Command register, only loadable while idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cmd_r <= '0;
    else if (bus_wr && is_reg && (addr_r == REG_CMD))
      cmd_r <= hwdata[15:0];
  end

  // Outcome of the last instruction for software
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      last_skip_r <= 1'b0;
      last_cycles_r <= '0;
    end
    else if (exec)
    begin
      last_skip_r <= alu.skip;
      last_cycles_r <= exec_cycles;
    end
  end

  // Working register: instruction result, else software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      working_register_r <= WORK_RST;
    else if (exec && alu.wr_work)
      working_register_r <= alu.result;
    else if (bus_wr && is_reg && (addr_r == REG_WORK))
      working_register_r <= hwdata[7:0];
  end

  // Status flags: of instructions only subtract and xor change them, else software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      flags_r <= FLAGS_RST;
    else if (exec)
      flags_r <= alu.flags;
    else if (bus_wr && is_reg && (addr_r == REG_FLAGS))
      flags_r <= hwdata[5:0];
  end

  // Table pointer, set by software only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      table_pointer_low_r <= BYTE_ZERO;
      table_pointer_high_r <= BYTE_ZERO;
    end
    else if (bus_wr && is_reg && (addr_r == REG_TBL_PTR))
    begin
      table_pointer_low_r <= hwdata[7:0];
      table_pointer_high_r <= hwdata[15:8];
    end
  end

  // Table high latch receives the fetched word's upper byte
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      table_high_latch_r <= BYTE_ZERO;
    else if (exec && alu.wr_tbl)
      table_high_latch_r <= pword[15:8];
  end

  // Data memory: no reset, so contents are unknown until written
  always_ff @(posedge hclk)
  begin
    if (exec && alu.wr_mem)
      dmem[cmd_r.addr] <= alu.result;
    else if (bus_wr && is_dmem)
      dmem[dmem_idx] <= hwdata[7:0];
  end

  // Program memory, loaded by software, read by table reads
  always_ff @(posedge hclk)
  begin
    if (bus_wr && is_pmem)
      pmem[pmem_idx] <= hwdata[15:0];
  end

endmodule

// *** test/eie_core_assertions.sv ***
`timescale 1ns/1ps
module eie_chk
  import eie_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus request
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // Bus answer
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Requests taken at this edge
  logic rd_take;
  logic wr_take;
  logic stat_rd_r;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;
  assign wr_take = hsel && htrans[1] && hready && hwrite;

  // Remember a status read; held through its wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_rd_r <= 1'h0;
    else if (hready)
      stat_rd_r <= rd_take && (haddr[12:0] == REG_STATUS);
  end

  AST_OKAY_RESP: assert property (hresp == 1'h0)
    else $error("response not OKAY");
  AST_READ_WAIT: assert property (rd_take |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (wr_take |=> hreadyout)
    else $error("write stalled");
  AST_WAIT_CAUSE: assert property (!hreadyout |-> $past(rd_take))
    else $error("wait state without read");
  AST_DATA_HOLD: assert property (hreadyout && $past(hreadyout)
    |-> $stable(hrdata))
    else $error("read data moved outside a read");
  AST_UPPER_ZERO: assert property (hreadyout |-> hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_SKIP_CYCLES: assert property ($rose(hreadyout) && stat_rd_r
    |-> hrdata[1] == (hrdata[5:4] == CYC_SKIP))
    else $error("skip and cycle count disagree");
  AST_STATUS_RSVD: assert property ($rose(hreadyout) && stat_rd_r
    |-> hrdata[31:6] == 26'h0 && hrdata[3:2] == 2'h0)
    else $error("status reserved bits set");

  // Main traffic seen
  cover property (rd_take);
  cover property (wr_take);
  cover property ($rose(hreadyout) && stat_rd_r && hrdata[1]);
endmodule

bind eie_core eie_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// *** test/extended_instruction_execute_tb_top.sv ***
`timescale 1ns/1ps
module extended_instruction_execute_tb_top
  import eie_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int errors, checks_done;

  // Single slave: its hreadyout is the bus hready
  eie_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  // 25 MHz clock
  initial
  begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    errors++;
    $display("BAD at %0t: wait ran out", $time);
    stop_test();
  endtask

  // One single transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [12:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'h1;
    haddr <= {19'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do
    begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 80);
    rd = hrdata;
    if (n >= 80)
      hang();
  endtask

  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'h1, a, d, x);
  endtask

  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    bus(1'h0, a, 32'h0, d);
  endtask

  function automatic logic [12:0] dma(input logic [7:0] i);
    return 13'h0400 + {3'h0, i, 2'h0};
  endfunction

  // Poll until the instruction engine is idle again
  task automatic idle(output logic [31:0] s);
    int n;
    n = 0;
    do
    begin
      rd(REG_STATUS, s);
      n++;
    end while (s[0] !== 1'h0 && n < 20);
    if (n >= 20)
      hang();
  endtask

  // Preload, execute one instruction, judge memory, work, flags, status
  task automatic rc(input eie_op_t op, input logic [2:0] bs,
                    input logic [7:0] a, w0, input logic [5:0] f0,
                    input logic [7:0] m0, em, ew, input logic [5:0] ef,
                    input logic es);
    logic [31:0] d;
    wr(REG_WORK, {24'h0, w0});
    wr(REG_FLAGS, {26'h0, f0});
    wr(dma(a), {24'h0, m0});
    wr(REG_CMD, {16'h0, a, bs, op});
    idle(d);
    chk(d, {26'h0, es ? CYC_SKIP : CYC_NORMAL, 2'h0, es, 1'h0});
    rd(dma(a), d);
    chk(d, {24'h0, em});
    rd(REG_WORK, d);
    chk(d, {24'h0, ew});
    rd(REG_FLAGS, d);
    chk(d, {26'h0, ef});
  endtask

  // Reset state, unmapped and read-only places, writes dropped while busy
  task automatic t_regs();
    logic [31:0] d;
    rd(REG_FLAGS, d);
    chk(d, 32'h0);
    rd(13'h001C, d);
    chk(d, 32'h0);
    wr(REG_TBL_HIGH, 32'h000000FF);
    rd(REG_TBL_HIGH, d);
    chk(d, 32'h0);
    wr(REG_WORK, 32'h00000077);
    wr(REG_CMD, {16'h0010, 3'h0, OP_SET_ALL_BITS});
    wr(REG_WORK, 32'h00000099);
    idle(d);
    rd(REG_WORK, d);
    chk(d, 32'h00000077);
    $display("t_regs done");
  endtask

  task automatic t_sub();
    rc(OP_SUB_BORROW_TO_MEM, 3'h0, 8'h40, 8'h10, 6'h3E, 8'h20,
       8'hEF, 8'h10, 6'h00, 1'h0);
    rc(OP_SUBTRACT_TO_WORK, 3'h0, 8'h41, 8'h80, 6'h00, 8'h01,
       8'h01, 8'h7F, 6'h09, 1'h0);
    rc(OP_SUBTRACT_TO_MEM, 3'h0, 8'h42, 8'h05, 6'h00, 8'h05,
       8'h00, 8'h05, 6'h37, 1'h0);
    $display("t_sub done");
  endtask

  // Wrap cases: 01 down and FF up both skip
  task automatic t_incdec();
    rc(OP_DEC_SKIP_ZERO_MEM, 3'h0, 8'h43, 8'h33, 6'h2A, 8'h01,
       8'h00, 8'h33, 6'h2A, 1'h1);
    rc(OP_DEC_SKIP_ZERO_MEM, 3'h0, 8'hFF, 8'h33, 6'h2A, 8'h00,
       8'hFF, 8'h33, 6'h2A, 1'h0);
    rc(OP_DEC_SKIP_ZERO_WORK, 3'h0, 8'h44, 8'h33, 6'h2A, 8'h01,
       8'h01, 8'h00, 6'h2A, 1'h1);
    rc(OP_INC_SKIP_ZERO_MEM, 3'h0, 8'h45, 8'h33, 6'h2A, 8'hFF,
       8'h00, 8'h33, 6'h2A, 1'h1);
    rc(OP_INC_SKIP_ZERO_WORK, 3'h0, 8'h46, 8'h33, 6'h2A, 8'h41,
       8'h41, 8'h42, 6'h2A, 1'h0);
    $display("t_incdec done");
  endtask

  task automatic t_setswap();
    rc(OP_SET_ALL_BITS, 3'h0, 8'h47, 8'h33, 6'h15, 8'h12,
       8'hFF, 8'h33, 6'h15, 1'h0);
    rc(OP_SET_BIT, 3'h5, 8'h48, 8'h33, 6'h15, 8'h00,
       8'h20, 8'h33, 6'h15, 1'h0);
    rc(OP_NIBBLE_EXCHANGE, 3'h0, 8'h49, 8'h33, 6'h15, 8'hA5,
       8'h5A, 8'h33, 6'h15, 1'h0);
    rc(OP_NIBBLE_EXCHANGE_WORK, 3'h0, 8'h4A, 8'h33, 6'h15, 8'h3C,
       8'h3C, 8'hC3, 6'h15, 1'h0);
    $display("t_setswap done");
  endtask

  task automatic t_skips();
    rc(OP_SKIP_IF_NONZERO_BIT, 3'h7, 8'h4B, 8'h33, 6'h2A, 8'h80,
       8'h80, 8'h33, 6'h2A, 1'h1);
    rc(OP_SKIP_IF_NONZERO_BIT, 3'h0, 8'h4B, 8'h33, 6'h2A, 8'h80,
       8'h80, 8'h33, 6'h2A, 1'h0);
    rc(OP_SKIP_IF_NONZERO, 3'h0, 8'h4C, 8'h33, 6'h2A, 8'h00,
       8'h00, 8'h33, 6'h2A, 1'h0);
    rc(OP_SKIP_IF_NONZERO, 3'h0, 8'h4C, 8'h33, 6'h2A, 8'h01,
       8'h01, 8'h33, 6'h2A, 1'h1);
    rc(OP_SKIP_IF_ZERO, 3'h0, 8'h4D, 8'h33, 6'h2A, 8'h00,
       8'h00, 8'h33, 6'h2A, 1'h1);
    rc(OP_SKIP_IF_ZERO, 3'h0, 8'h4D, 8'h33, 6'h2A, 8'h10,
       8'h10, 8'h33, 6'h2A, 1'h0);
    rc(OP_MOVE_TEST_SKIP, 3'h0, 8'h4E, 8'h33, 6'h2A, 8'h00,
       8'h00, 8'h00, 6'h2A, 1'h1);
    rc(OP_MOVE_TEST_SKIP, 3'h0, 8'h4E, 8'h33, 6'h2A, 8'h7E,
       8'h7E, 8'h7E, 6'h2A, 1'h0);
    rc(OP_SKIP_IF_ZERO_BIT, 3'h3, 8'h4F, 8'h33, 6'h2A, 8'hF7,
       8'hF7, 8'h33, 6'h2A, 1'h1);
    rc(OP_SKIP_IF_ZERO_BIT, 3'h2, 8'h4F, 8'h33, 6'h2A, 8'hF7,
       8'hF7, 8'h33, 6'h2A, 1'h0);
    $display("t_skips done");
  endtask

  // Xor touches zero only; table read splits the word
  task automatic t_xor_table();
    logic [31:0] d;
    rc(OP_XOR_TO_WORK, 3'h0, 8'h50, 8'h5A, 6'h01, 8'h5A,
       8'h5A, 8'h00, 6'h05, 1'h0);
    rc(OP_XOR_TO_MEM, 3'h0, 8'h51, 8'h0F, 6'h3F, 8'hF0,
       8'hFF, 8'h0F, 6'h3B, 1'h0);
    wr(13'h0800 + {2'h0, 9'h1A3, 2'h0}, 32'h0000BEEF);
    wr(REG_TBL_PTR, 32'h000001A3);
    rc(OP_TABLE_READ_PAGED, 3'h0, 8'h52, 8'h11, 6'h15, 8'h00,
       8'hEF, 8'h11, 6'h15, 1'h0);
    rd(REG_TBL_HIGH, d);
    chk(d, 32'h000000BE);
    $display("t_xor_table done");
  endtask

  // Reset for 3 cycles, then the scenarios
  initial
  begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    t_regs();
    t_sub();
    t_incdec();
    t_setswap();
    t_skips();
    t_xor_table();
    stop_test();
  end
endmodule
